// ### dcs_defines.svh
// constants for the data cache snoop controller
// assumes a 32-bit physical address and 16-byte lines of four long words
// How it works
// - inhibited or serialized modes bypass cache, run bus transfer, raise inhibit out
// - inhibited access hitting a line invalidates it, pushing it first if dirty
// - serialized accesses run one at a time in order, held uninterrupted
// - locked accesses are always handled as serialized
// - exception stack and vector misses never allocate; hits follow the mode
// - block moves never allocate; read hits served, write hits invalidate and write
// - locked hit while disabled stops the next non-locked miss allocating
// - bus transfers change line state only when marked snoopable
// - read miss fills the line valid; snooped read miss changes nothing
// - copyback write miss fills, merges, sets dirty per written long word
// - write-through write miss goes to memory only; snooped write miss ignored
// - read hit: no bus, no change; address bit 3 picks the half-line
// - snooped read: valid hit ignored, dirty hit inhibits memory and supplies
// - snooped read hit invalidates the line only when invalidation is requested
// - write-through write hit updates long words and writes memory
// - copyback write hit updates line, sets dirty bits, no bus write
// - snooped line write hitting a line always invalidates it
// - snooped small sink write on dirty hit merges, sets dirty, inhibits memory
// - snoop code 00 none, 01 keep or sink, 10 invalidate, 11 none
// - snooping works while the cache is disabled
// - snoop wins the cache over a processor access
// - line is invalid, valid with clean words, or dirty
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
`define DCS_CM_WT      2'h0
`define DCS_CM_CB      2'h1
`define DCS_CM_NSER    2'h2
`define DCS_CM_SER     2'h3
`define DCS_SNP_NONE   2'h0
`define DCS_SNP_KEEP   2'h1
`define DCS_SNP_INV    2'h2
`define DCS_HALF_BIT   3
`define DCS_WSEL_LO    2
`define DCS_IDX_LO     4
`define DCS_TAG_LO     4
`define DCS_REG_CTRL   4'h0
`define DCS_REG_STAT   4'h1
`define DCS_CTRL_EN    0
`endif

// ### dcs_pkg.sv
// types for the data cache snoop controller
// assumes dcs_defines.svh for encodings
package dcs_pkg;
  typedef enum logic [1:0] {DCS_K_NORMAL, DCS_K_LOCKED, DCS_K_EXCEPT, DCS_K_BMOVE} dcs_kind_t;
  typedef enum logic [2:0] {DCS_ST_IDLE, DCS_ST_PUSH, DCS_ST_FILL, DCS_ST_SINGLE, DCS_ST_ACK} dcs_state_t;
  typedef struct packed {
    logic         v;
    logic [3:0]   d;
    logic [27:0]  tag;
    logic [127:0] data;
  } dcs_line_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [1:0]  mode;
    dcs_kind_t   kind;
  } dcs_cpu_req_t;
  typedef struct packed {
    logic        ack;
    logic        serial_hold;
    logic [63:0] rdata;
  } dcs_cpu_rsp_t;
  typedef struct packed {
    logic         req;
    logic         we;
    logic         line;
    logic         inhibit_out_signal;
    logic [31:0]  addr;
    logic [3:0]   be;
    logic [127:0] wdata;
  } dcs_bus_req_t;
  typedef struct packed {
    logic         ack;
    logic [127:0] rdata;
  } dcs_bus_rsp_t;
  typedef struct packed {
    logic        valid;
    logic        snoopable;
    logic        we;
    logic        line;
    logic        snoop_ctl_hi;
    logic        snoop_ctl_lo;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } dcs_snp_req_t;
  typedef struct packed {
    logic         done;
    logic         inhibit_mem;
    logic [127:0] rdata;
  } dcs_snp_rsp_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } dcs_reg_req_t;
endpackage : dcs_pkg

// ### dcs_top.sv
// data cache control with bus snooping, direct mapped, flip-flop storage
// assumes held cpu requests, one-cycle bus acks and one-cycle snoop pulses
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "dcs_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dcs_top #(
  parameter int SET_W = 4
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire dcs_pkg::dcs_reg_req_t reg_req,
  output var  logic [31:0]       reg_rdata,
  // integer unit side
  input  wire dcs_pkg::dcs_cpu_req_t cpu_req,
  output var  dcs_pkg::dcs_cpu_rsp_t cpu_rsp,
  // system bus master side
  output var  dcs_pkg::dcs_bus_req_t bus_req,
  input  wire dcs_pkg::dcs_bus_rsp_t bus_rsp,
  // snoop side
  input  wire dcs_pkg::dcs_snp_req_t snp_req,
  output var  dcs_pkg::dcs_snp_rsp_t snp_rsp
);
  localparam int SETS = 1 << SET_W;

  typedef struct packed {
    dcs_pkg::dcs_line_t [SETS-1:0] lines;
    dcs_pkg::dcs_state_t           st;
    logic                          enable;
    logic                          lock_nalloc;
    logic                          fill_next;
    logic [31:0]                   reg_rdata;
    dcs_pkg::dcs_cpu_rsp_t         cpu;
    dcs_pkg::dcs_bus_req_t         bus;
    dcs_pkg::dcs_snp_rsp_t         snp;
  } dcs_regs_t;

  dcs_regs_t s_q;
  dcs_regs_t s_d;

  // merge a long word into a line under byte enables
  function automatic logic [127:0] dcs_merge(input logic [127:0] data, input logic [1:0] wsel,
                                             input logic [31:0] wdata, input logic [3:0] be);
    logic [127:0] r;
    r = data;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[{wsel, 5'h00} + b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return r;
  endfunction : dcs_merge

  function automatic logic [63:0] dcs_half(input logic [127:0] data, input logic sel);
    return sel ? data[127:64] : data[63:0];
  endfunction : dcs_half

  // cpu access decode
  logic [SET_W-1:0]   c_idx;
  logic [1:0]         c_wsel;
  logic               c_half;
  logic               c_hit;
  logic               c_dirty;
  logic               c_locked;
  logic               c_inhib;
  logic               c_nalloc;
  dcs_pkg::dcs_line_t c_line;

  // snoop decode
  logic [SET_W-1:0]   s_idx;
  logic [1:0]         s_wsel;
  logic [1:0]         s_ctl;
  logic               s_hit;
  logic               s_dirty;
  logic               s_active;
  dcs_pkg::dcs_line_t s_line;

  assign c_idx    = cpu_req.addr[`DCS_IDX_LO +: SET_W];
  assign c_wsel   = cpu_req.addr[`DCS_WSEL_LO +: 2];
  assign c_half   = cpu_req.addr[`DCS_HALF_BIT];
  assign c_line   = s_q.lines[c_idx];
  assign c_hit    = c_line.v && (c_line.tag == cpu_req.addr[31:`DCS_TAG_LO]);
  assign c_dirty  = c_hit && (|c_line.d);
  assign c_locked = (cpu_req.kind == dcs_pkg::DCS_K_LOCKED);
  assign c_inhib  = c_locked || (cpu_req.mode == `DCS_CM_NSER)
                 || (cpu_req.mode == `DCS_CM_SER);
  assign c_nalloc = (cpu_req.kind == dcs_pkg::DCS_K_EXCEPT) || (cpu_req.kind == dcs_pkg::DCS_K_BMOVE)
                 || s_q.lock_nalloc;

  assign s_idx    = snp_req.addr[`DCS_IDX_LO +: SET_W];
  assign s_wsel   = snp_req.addr[`DCS_WSEL_LO +: 2];
  assign s_ctl    = {snp_req.snoop_ctl_hi, snp_req.snoop_ctl_lo};
  assign s_line   = s_q.lines[s_idx];
  assign s_hit    = s_line.v && (s_line.tag == snp_req.addr[31:`DCS_TAG_LO]);
  assign s_dirty  = s_hit && (|s_line.d);
  assign s_active = snp_req.valid && snp_req.snoopable
                 && ((s_ctl == `DCS_SNP_KEEP) || (s_ctl == `DCS_SNP_INV));

  always_comb begin
    dcs_pkg::dcs_line_t nl;
    nl = '0;
    s_d = s_q;
    s_d.cpu.ack     = 1'b0;
    s_d.snp.done    = 1'b0;
    s_d.snp.inhibit_mem = 1'b0;
    s_d.reg_rdata   = '0;

    // register port
    if (reg_req.wr && (reg_req.addr == `DCS_REG_CTRL)) begin
      s_d.enable = reg_req.wdata[`DCS_CTRL_EN];
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `DCS_REG_CTRL: s_d.reg_rdata = {31'h00000000, s_q.enable};
        `DCS_REG_STAT: s_d.reg_rdata = {27'h0000000, s_q.lock_nalloc, s_q.fill_next, 3'(s_q.st)};
        default:       s_d.reg_rdata = '0;
      endcase
    end

    unique case (s_q.st)
      dcs_pkg::DCS_ST_IDLE: begin
        // snoop takes the cache first; the cpu waits a cycle
        if (cpu_req.req && !snp_req.valid) begin
          s_d.cpu.serial_hold = c_inhib && (cpu_req.mode == `DCS_CM_SER || c_locked);
          s_d.bus.addr  = cpu_req.addr;
          s_d.bus.be    = cpu_req.be;
          s_d.bus.we    = cpu_req.we;
          s_d.bus.wdata = {4{cpu_req.wdata}};
          s_d.bus.line  = 1'b0;
          s_d.bus.inhibit_out_signal = c_inhib;
          if (c_inhib || !s_q.enable) begin
            if (c_locked && c_hit && !s_q.enable) begin
              s_d.lock_nalloc = 1'b1;
            end
            s_d.bus.req = 1'b1;
            s_d.st      = dcs_pkg::DCS_ST_SINGLE;
            if (c_inhib && c_hit) begin
              s_d.lines[c_idx].v = 1'b0;
              s_d.lines[c_idx].d = '0;
              if (c_dirty) begin
                s_d.bus.we    = 1'b1;
                s_d.bus.line  = 1'b1;
                s_d.bus.inhibit_out_signal = 1'b0;
                s_d.bus.addr  = {c_line.tag, 4'h0};
                s_d.bus.wdata = c_line.data;
                s_d.fill_next = 1'b0;
                s_d.st        = dcs_pkg::DCS_ST_PUSH;
              end
            end
          end else if (c_hit) begin
            if (!cpu_req.we) begin
              s_d.cpu.rdata = dcs_half(c_line.data, c_half);
              s_d.cpu.ack   = 1'b1;
              s_d.st        = dcs_pkg::DCS_ST_ACK;
            end else if (cpu_req.kind == dcs_pkg::DCS_K_BMOVE) begin
              s_d.lines[c_idx].v = 1'b0;
              s_d.lines[c_idx].d = '0;
              s_d.bus.req = 1'b1;
              s_d.st      = dcs_pkg::DCS_ST_SINGLE;
            end else if (cpu_req.mode == `DCS_CM_WT) begin
              s_d.lines[c_idx].data = dcs_merge(c_line.data, c_wsel, cpu_req.wdata, cpu_req.be);
              s_d.bus.req = 1'b1;
              s_d.st      = dcs_pkg::DCS_ST_SINGLE;
            end else begin
              s_d.lines[c_idx].data = dcs_merge(c_line.data, c_wsel, cpu_req.wdata, cpu_req.be);
              s_d.lines[c_idx].d[c_wsel] = 1'b1;
              s_d.cpu.ack = 1'b1;
              s_d.st      = dcs_pkg::DCS_ST_ACK;
            end
          end else begin
            if (s_q.lock_nalloc && !c_locked) begin
              s_d.lock_nalloc = 1'b0;
            end
            s_d.bus.req = 1'b1;
            if (c_nalloc || (cpu_req.we && cpu_req.mode == `DCS_CM_WT)) begin
              s_d.st = dcs_pkg::DCS_ST_SINGLE;
            end else begin
              s_d.bus.we   = 1'b0;
              s_d.bus.line = 1'b1;
              s_d.bus.addr = {cpu_req.addr[31:`DCS_TAG_LO], 4'h0};
              s_d.st       = dcs_pkg::DCS_ST_FILL;
              if (c_line.v && (|c_line.d)) begin
                s_d.bus.we    = 1'b1;
                s_d.bus.addr  = {c_line.tag, 4'h0};
                s_d.bus.wdata = c_line.data;
                s_d.fill_next = 1'b1;
                s_d.st        = dcs_pkg::DCS_ST_PUSH;
              end
            end
          end
        end
      end
      dcs_pkg::DCS_ST_PUSH: begin
        if (bus_rsp.ack) begin
          s_d.bus.req   = 1'b1;
          s_d.bus.line  = s_q.fill_next;
          s_d.bus.we    = s_q.fill_next ? 1'b0 : cpu_req.we;
          s_d.bus.addr  = s_q.fill_next ? {cpu_req.addr[31:`DCS_TAG_LO], 4'h0} : cpu_req.addr;
          s_d.bus.wdata = {4{cpu_req.wdata}};
          s_d.bus.inhibit_out_signal = !s_q.fill_next;
          s_d.st = s_q.fill_next ? dcs_pkg::DCS_ST_FILL : dcs_pkg::DCS_ST_SINGLE;
        end
      end
      dcs_pkg::DCS_ST_FILL: begin
        if (bus_rsp.ack) begin
          s_d.bus.req = 1'b0;
          nl.v    = 1'b1;
          nl.d    = '0;
          nl.tag  = cpu_req.addr[31:`DCS_TAG_LO];
          nl.data = bus_rsp.rdata;
          if (cpu_req.we) begin
            nl.data        = dcs_merge(bus_rsp.rdata, c_wsel, cpu_req.wdata, cpu_req.be);
            nl.d[c_wsel]   = 1'b1;
          end
          s_d.lines[c_idx] = nl;
          s_d.cpu.rdata = dcs_half(bus_rsp.rdata, c_half);
          s_d.cpu.ack   = 1'b1;
          s_d.st        = dcs_pkg::DCS_ST_ACK;
        end
      end
      dcs_pkg::DCS_ST_SINGLE: begin
        if (bus_rsp.ack) begin
          s_d.bus.req   = 1'b0;
          s_d.cpu.rdata = dcs_half(bus_rsp.rdata, c_half);
          s_d.cpu.ack   = 1'b1;
          s_d.st        = dcs_pkg::DCS_ST_ACK;
        end
      end
      dcs_pkg::DCS_ST_ACK: begin
        s_d.bus.inhibit_out_signal = 1'b0;
        s_d.cpu.serial_hold = 1'b0;
        s_d.st = dcs_pkg::DCS_ST_IDLE;
      end
    endcase

    // snoop, independent of the enable bit
    if (snp_req.valid) begin
      s_d.snp.done  = 1'b1;
      s_d.snp.rdata = '0;
    end
    if (s_active && s_hit) begin
      if (!snp_req.we) begin
        if (s_dirty) begin
          s_d.snp.inhibit_mem = 1'b1;
          s_d.snp.rdata       = s_line.data;
        end
        if (s_ctl == `DCS_SNP_INV) begin
          s_d.lines[s_idx].v = 1'b0;
          s_d.lines[s_idx].d = '0;
        end
      end else if (!snp_req.line && s_ctl == `DCS_SNP_KEEP && s_dirty) begin
        s_d.lines[s_idx].data = dcs_merge(s_line.data, s_wsel, snp_req.wdata, snp_req.be);
        s_d.lines[s_idx].d[s_wsel] = 1'b1;
        s_d.snp.inhibit_mem = 1'b1;
      end else begin
        s_d.lines[s_idx].v = 1'b0;
        s_d.lines[s_idx].d = '0;
      end
    end

    if (reset) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign reg_rdata = s_q.reg_rdata;
  assign cpu_rsp   = s_q.cpu;
  assign bus_req   = s_q.bus;
  assign snp_rsp   = s_q.snp;
endmodule : dcs_top
`default_nettype wire

// ### dcs_asserts.sv
// port checker for the data cache snoop controller
// assumes a bind from the bench top and one clock domain
`timescale 1ns/10ps
`default_nettype none
module dcs_asserts #(
  parameter int SET_W = 4
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  reset,
  // watched ports
  input wire dcs_pkg::dcs_reg_req_t reg_req,
  input wire logic [31:0]           reg_rdata,
  input wire dcs_pkg::dcs_cpu_req_t cpu_req,
  input wire dcs_pkg::dcs_cpu_rsp_t cpu_rsp,
  input wire dcs_pkg::dcs_bus_req_t bus_req,
  input wire dcs_pkg::dcs_bus_rsp_t bus_rsp,
  input wire dcs_pkg::dcs_snp_req_t snp_req,
  input wire dcs_pkg::dcs_snp_rsp_t snp_rsp
);
  default clocking dcs_cb @(posedge clk); endclocking
  default disable iff (reset);
  // bus request still waiting
  sequence s_bus_wait;
    bus_req.req && !bus_rsp.ack;
  endsequence
  // snoop that must change nothing
  sequence s_snp_off;
    snp_req.valid && (!snp_req.snoopable || snp_req.snoop_ctl_hi == snp_req.snoop_ctl_lo);
  endsequence
  a_snoop_done: assert property (snp_req.valid |=> snp_rsp.done)
    else $error("snoop not answered");
  a_done_cause: assert property (snp_rsp.done |-> $past(snp_req.valid))
    else $error("snoop done without request");
  a_snoop_ignored: assert property (s_snp_off |=> !snp_rsp.inhibit_mem)
    else $error("memory inhibited on ignored snoop");
  a_inhibit_with_done: assert property (snp_rsp.inhibit_mem |-> snp_rsp.done)
    else $error("inhibit outside snoop answer");
  a_inhibit_single: assert property (bus_req.req && bus_req.inhibit_out_signal |-> !bus_req.line)
    else $error("inhibited transfer as line");
  a_bus_hold: assert property (s_bus_wait |=> $stable(bus_req))
    else $error("bus request changed while waiting");
  a_serial_inhibit: assert property (cpu_rsp.serial_hold && bus_req.req && !bus_req.line
    |-> bus_req.inhibit_out_signal)
    else $error("serialized single not inhibited");
  a_ack_pulse: assert property (cpu_rsp.ack |=> !cpu_rsp.ack)
    else $error("cpu ack longer than a cycle");
  a_snoop_first: assert property (snp_req.valid && !bus_rsp.ack |=> !cpu_rsp.ack)
    else $error("cpu served during snoop");
  a_reg_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_req.rd))
    else $error("read data outside its slot");
endmodule : dcs_asserts
`default_nettype wire

// ### dcs_bus_model.sv
// system bus memory model with prompt or slow acknowledge
// assumes the controller holds its request until the ack pulse
`timescale 1ns/10ps
`default_nettype none
module dcs_bus_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // controller bus
  input  wire dcs_pkg::dcs_bus_req_t bus_req,
  output var  dcs_pkg::dcs_bus_rsp_t bus_rsp,
  // pacing and observation
  input  wire logic                  slow,
  output var  logic [15:0]           n_xfer,
  output var  dcs_pkg::dcs_bus_req_t last,
  output var  logic [127:0]          pushed
);
  logic [127:0] mem [0:63];
  logic [1:0]   wait_q;
  logic [5:0]   idx;
  assign idx = bus_req.addr[9:4];
  initial begin
    bus_rsp = '0;
    for (int i = 0; i < 64; i++) begin
      mem[i] = {4{32'hA0000000 | i}};
    end
  end
  always @(posedge clk) begin
    bus_rsp.ack <= 1'b0;
    bus_rsp.rdata <= ~bus_rsp.rdata;
    if (reset) begin
      wait_q <= 2'h0;
      n_xfer <= 16'h0;
    end else if (bus_req.req && !bus_rsp.ack) begin
      if (wait_q != (slow ? 2'h3 : 2'h0)) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q <= 2'h0;
        bus_rsp.ack <= 1'b1;
        bus_rsp.rdata <= mem[idx];
        n_xfer <= n_xfer + 16'h1;
        last <= bus_req;
        if (bus_req.we && bus_req.line) begin
          mem[idx] <= bus_req.wdata;
          pushed <= bus_req.wdata;
        end else if (bus_req.we) begin
          for (int b = 0; b < 4; b++) begin
            if (bus_req.be[b]) begin
              mem[idx][{bus_req.addr[3:2], 5'h0} + 8 * b +: 8] <= bus_req.wdata[8 * b +: 8];
            end
          end
        end
      end
    end
  end
endmodule : dcs_bus_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the data cache snoop controller
// assumes the bus model file and the checker file
`timescale 1ns/10ps
`default_nettype none
`include "dcs_defines.svh"
module tb_top;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  slow = 1'b0;
  dcs_pkg::dcs_reg_req_t reg_req = '0;
  dcs_pkg::dcs_cpu_req_t cpu_req = '0;
  dcs_pkg::dcs_snp_req_t snp_req = '0;
  dcs_pkg::dcs_cpu_rsp_t cpu_rsp;
  dcs_pkg::dcs_bus_req_t bus_req;
  dcs_pkg::dcs_bus_rsp_t bus_rsp;
  dcs_pkg::dcs_snp_rsp_t snp_rsp;
  dcs_pkg::dcs_bus_req_t last;
  logic [31:0]           reg_rdata;
  logic [15:0]           n_xfer;
  logic [15:0]           x0;
  logic [127:0]          pushed;
  logic [63:0]           rd_q;
  logic [31:0]           rr;
  logic                  held;
  int                    n_fail = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  always #10 clk = ~clk;
  dcs_top #(.SET_W(4)) u_dut (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .snp_req(snp_req), .snp_rsp(snp_rsp));
  dcs_bus_model u_bus (.clk(clk), .reset(reset), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .slow(slow), .n_xfer(n_xfer), .last(last), .pushed(pushed));
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] pw(input logic [31:0] a);
    return 32'hA0000000 | {26'h0, a[9:4]};
  endfunction : pw
  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
    @(negedge clk);
    rr = reg_rdata;
    @(posedge clk);
  endtask : reg_acc
  task automatic cpu(input logic we, input logic [31:0] a, input logic [31:0] d,
                     input logic [1:0] m, input logic [1:0] k);
    int n;
    x0 = n_xfer;
    held = 1'b0;
    @(posedge clk);
    cpu_req <= '{req: 1'b1, we: we, addr: a, wdata: d, be: 4'hF, mode: m, kind: dcs_pkg::dcs_kind_t'(k)};
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      held |= (cpu_rsp.serial_hold === 1'b1);
      if (cpu_rsp.ack === 1'b1) break;
    end
    if (n == 300) n_fail++;
    rd_q = cpu_rsp.rdata;
    cpu_req <= '0;
  endtask : cpu
  task automatic snoop(input logic we, input logic ln, input logic [1:0] sc, input logic sn,
                       input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    snp_req <= '{valid: 1'b1, snoopable: sn, we: we, line: ln, snoop_ctl_hi: sc[1],
                 snoop_ctl_lo: sc[0], addr: a, wdata: d, be: 4'hF};
    @(posedge clk);
    snp_req <= '0;
    @(posedge clk);
    chk("snoop_done", snp_rsp.done, 1'b1);
  endtask : snoop
  task automatic t_regs();
    reg_acc(1'b0, 4'h0, 32'h0);
    chk("ctrl_reset", rr, 32'h0);
    reg_acc(1'b1, 4'h9, 32'h1);
    reg_acc(1'b0, 4'h9, 32'h0);
    chk("unmapped", rr, 32'h0);
    reg_acc(1'b1, 4'h0, 32'h1);
    reg_acc(1'b0, 4'h0, 32'h0);
    chk("ctrl_en", rr, 32'h1);
  endtask : t_regs
  task automatic t_read();
    cpu(1'b0, 32'h110, 32'h0, `DCS_CM_CB, 2'h0);
    chk("rm_bus", n_xfer - x0, 16'h1);
    chk("rm_data", rd_q, {2{pw(32'h110)}});
    cpu(1'b0, 32'h118, 32'h0, `DCS_CM_CB, 2'h0);
    chk("rh_bus", n_xfer - x0, 16'h0);
    chk("rh_half", rd_q, {2{pw(32'h110)}});
  endtask : t_read
  task automatic t_copyback();
    slow <= 1'b1;
    cpu(1'b1, 32'h220, 32'h11111111, `DCS_CM_CB, 2'h0);
    chk("wm_fill", last.line, 1'b1);
    cpu(1'b1, 32'h224, 32'h22222222, `DCS_CM_CB, 2'h0);
    chk("wh_nobus", n_xfer - x0, 16'h0);
    snoop(1'b0, 1'b1, 2'h1, 1'b1, 32'h220, 32'h0);
    chk("sr_inh", snp_rsp.inhibit_mem, 1'b1);
    chk("sr_data", snp_rsp.rdata, {{2{pw(32'h220)}}, 64'h2222222211111111});
    snoop(1'b0, 1'b1, 2'h2, 1'b1, 32'h220, 32'h0);
    chk("sr_inv_inh", snp_rsp.inhibit_mem, 1'b1);
    snoop(1'b0, 1'b1, 2'h1, 1'b1, 32'h220, 32'h0);
    chk("sr_gone", snp_rsp.inhibit_mem, 1'b0);
    slow <= 1'b0;
  endtask : t_copyback
  task automatic t_wt();
    cpu(1'b1, 32'h330, 32'h33, `DCS_CM_WT, 2'h0);
    chk("wtm_single", {n_xfer - x0, last.line}, {16'h1, 1'b0});
    cpu(1'b0, 32'h330, 32'h0, `DCS_CM_WT, 2'h0);
    chk("wtm_noalloc", {n_xfer - x0, rd_q}, {16'h1, pw(32'h330), 32'h33});
    cpu(1'b1, 32'h334, 32'h44, `DCS_CM_WT, 2'h0);
    chk("wth_write", {n_xfer - x0, last.we}, {16'h1, 1'b1});
    cpu(1'b0, 32'h330, 32'h0, `DCS_CM_WT, 2'h0);
    chk("wth_update", {n_xfer - x0, rd_q}, {16'h0, 64'h0000004400000033});
  endtask : t_wt
  task automatic t_inhibit();
    cpu(1'b1, 32'h440, 32'h55, `DCS_CM_CB, 2'h0);
    cpu(1'b0, 32'h440, 32'h0, `DCS_CM_NSER, 2'h0);
    chk("inh_push", {n_xfer - x0, pushed[31:0]}, {16'h2, 32'h55});
    chk("inh_out", {last.inhibit_out_signal, last.line, rd_q[31:0]}, {2'h2, 32'h55});
    cpu(1'b0, 32'h440, 32'h0, `DCS_CM_CB, 2'h0);
    chk("inh_gone", n_xfer - x0, 16'h1);
    cpu(1'b0, 32'h448, 32'h0, `DCS_CM_SER, 2'h0);
    chk("ser_inv", {n_xfer - x0, held, last.inhibit_out_signal}, {16'h1, 2'h3});
    reg_acc(1'b1, 4'h0, 32'h0);
    cpu(1'b0, 32'h110, 32'h0, `DCS_CM_CB, dcs_pkg::DCS_K_LOCKED);
    chk("lock_ser", {held, last.inhibit_out_signal}, 2'h3);
    reg_acc(1'b0, 4'h1, 32'h0);
    chk("stat_lock", rr, 32'h10);
    reg_acc(1'b1, 4'h0, 32'h1);
    cpu(1'b0, 32'h660, 32'h0, `DCS_CM_CB, 2'h0);
    cpu(1'b0, 32'h660, 32'h0, `DCS_CM_CB, 2'h0);
    chk("lock_noalloc", n_xfer - x0, 16'h1);
  endtask : t_inhibit
  task automatic t_special();
    cpu(1'b0, 32'h770, 32'h0, `DCS_CM_CB, dcs_pkg::DCS_K_EXCEPT);
    cpu(1'b0, 32'h770, 32'h0, `DCS_CM_CB, 2'h0);
    chk("exc_noalloc", n_xfer - x0, 16'h1);
    cpu(1'b0, 32'h780, 32'h0, `DCS_CM_CB, dcs_pkg::DCS_K_BMOVE);
    cpu(1'b0, 32'h780, 32'h0, `DCS_CM_CB, 2'h0);
    chk("bm_noalloc", n_xfer - x0, 16'h1);
    cpu(1'b1, 32'h780, 32'h99, `DCS_CM_CB, dcs_pkg::DCS_K_BMOVE);
    chk("bm_write", n_xfer - x0, 16'h1);
    cpu(1'b0, 32'h780, 32'h0, `DCS_CM_CB, 2'h0);
    chk("bm_inval", {n_xfer - x0, rd_q[31:0]}, {16'h1, 32'h99});
  endtask : t_special
  task automatic t_snoop();
    cpu(1'b0, 32'h990, 32'h0, `DCS_CM_CB, 2'h0);
    snoop(1'b1, 1'b1, 2'h1, 1'b1, 32'h990, 32'h0);
    cpu(1'b0, 32'h990, 32'h0, `DCS_CM_CB, 2'h0);
    chk("sw_line_inv", n_xfer - x0, 16'h1);
    cpu(1'b1, 32'h550, 32'h77, `DCS_CM_CB, 2'h0);
    reg_acc(1'b1, 4'h0, 32'h0);
    for (int i = 0; i < 3; i++) begin
      snoop(1'b0, 1'b1, i == 0 ? 2'h1 : (i == 1 ? 2'h0 : 2'h3), i != 0, 32'h550, 32'h0);
      chk("snp_ignored", snp_rsp.inhibit_mem, 1'b0);
    end
    snoop(1'b1, 1'b0, 2'h1, 1'b1, 32'h554, 32'hAB);
    chk("sink_inh", snp_rsp.inhibit_mem, 1'b1);
    snoop(1'b0, 1'b1, 2'h1, 1'b1, 32'h550, 32'h0);
    chk("sink_data", snp_rsp.rdata, {{2{pw(32'h550)}}, 64'h000000AB00000077});
    reg_acc(1'b1, 4'h0, 32'h1);
  endtask : t_snoop
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_read();
    t_copyback();
    t_wt();
    t_inhibit();
    t_special();
    t_snoop();
    complete_run();
  end
endmodule : tb_top
bind dcs_top dcs_asserts #(.SET_W(SET_W)) u_chk (.clk(clk), .reset(reset), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .snp_req(snp_req), .snp_rsp(snp_rsp));
`default_nettype wire
